// ---- logic/tbspi_top.sv ----
// Purpose: Serial slave port and power modes of a touch button controller
// Assumes: Host clock idles high, bytes MSB first, long gaps between bytes
// Notes: Link logic runs on the serial clock; core reads it across a toggle

module tbspi_fifo #(
  parameter int W = 32,
  parameter int D = 32
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock)
  begin
    if (push)
      mem[wr_reg] <= in_data;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module tbspi_top #(
  parameter int BTN_W      = 18,
  parameter int INIT_CYC   = tbspi_pkg::INIT_CYCLES,
  parameter int RESYNC_CYC = tbspi_pkg::RESYNC_CYCLES,
  parameter int UNIT_CYC   = tbspi_pkg::SAVE_UNIT_CYC
) (
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  input  wire logic                 iface_sel0_or_serial_clock,
  input  wire logic                 iface_sel1_or_serial_in,
  output logic                      iface_sel2_or_serial_out,
  output logic                      data_request_n,
  input  wire logic                 power_save_n,
  input  wire logic [7:0]           power_save_time,
  input  wire logic [BTN_W-1:0]     button_state,
  input  wire logic                 reply_valid,
  input  wire tbspi_pkg::tbspi_pkt_t reply_pkt,
  output logic                      cmd_valid,
  output tbspi_pkg::tbspi_pkt_t     cmd_pkt,
  output tbspi_pkg::tbspi_mode_t    mode,
  output logic                      scan_en,
  output logic                      scan_fast,
  output logic [3:0]                sensitivity
);
  wire sck = iface_sel0_or_serial_clock;

  // Link domain
  logic       link_clr_reg;
  logic       link_rst_n;
  logic [2:0] bit_cnt_reg;
  logic       in_bit_reg;
  logic [7:0] shift_reg;
  logic [7:0] rx_hold_reg;
  logic       byte_tgl_reg;
  logic       bit_tgl_reg;
  logic       out_reg;
  logic [7:0] tx_word_reg;

  // Core clear drives a flop-made reset; released while the clock stands still
  assign link_rst_n = arst_n & ~link_clr_reg;

  always_ff @(posedge sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      bit_cnt_reg  <= '0;
      in_bit_reg   <= 1'b0;
      rx_hold_reg  <= '0;
      byte_tgl_reg <= 1'b0;
      bit_tgl_reg  <= 1'b0;
    end
    else
    begin
      in_bit_reg  <= iface_sel1_or_serial_in;
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      bit_tgl_reg <= ~bit_tgl_reg;
      if (bit_cnt_reg == 3'd7)
      begin
        rx_hold_reg  <= {shift_reg[6:0], iface_sel1_or_serial_in};
        byte_tgl_reg <= ~byte_tgl_reg;
      end
    end
  end

  // Same register carries outgoing and incoming bits
  always_ff @(negedge sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      shift_reg <= '0;
      out_reg   <= 1'b1;
    end
    else if (bit_cnt_reg == 3'd0)
    begin
      // Word held stable by the core across the byte gap
      out_reg   <= tx_word_reg[7];
      shift_reg <= {tx_word_reg[6:0], 1'b0};
    end
    else
    begin
      out_reg   <= shift_reg[7];
      shift_reg <= {shift_reg[6:0], in_bit_reg};
    end
  end

  assign iface_sel2_or_serial_out = out_reg;

  // Crossing into the core
  logic [2:0] byte_sync_reg;
  logic [2:0] bit_sync_reg;
  logic [1:0] ps_sync_reg;
  logic       byte_evt;
  logic       bit_evt;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      byte_sync_reg <= '0;
      bit_sync_reg  <= '0;
      ps_sync_reg   <= 2'b11;
    end
    else
    begin
      byte_sync_reg <= {byte_sync_reg[1:0], byte_tgl_reg};
      bit_sync_reg  <= {bit_sync_reg[1:0], bit_tgl_reg};
      ps_sync_reg   <= {ps_sync_reg[0], power_save_n};
    end
  end

  assign byte_evt = byte_sync_reg[2] ^ byte_sync_reg[1];
  assign bit_evt  = bit_sync_reg[2] ^ bit_sync_reg[1];
  wire   ps_high  = ps_sync_reg[1];

  // Idle gap resync
  logic [$clog2(RESYNC_CYC+1)-1:0] gap_cnt_reg;
  logic                            gap_armed_reg;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gap_cnt_reg   <= '0;
      gap_armed_reg <= 1'b0;
      link_clr_reg  <= 1'b0;
    end
    else
    begin
      link_clr_reg <= 1'b0;
      if (bit_evt)
      begin
        gap_cnt_reg   <= '0;
        gap_armed_reg <= 1'b1;
      end
      else if (gap_armed_reg)
      begin
        if (gap_cnt_reg == ($bits(gap_cnt_reg))'(RESYNC_CYC - 1))
        begin
          gap_armed_reg <= 1'b0;
          link_clr_reg  <= 1'b1;
        end
        else
          gap_cnt_reg <= gap_cnt_reg + 1'b1;
      end
    end
  end

  // Power-on initialisation
  logic [$clog2(INIT_CYC+1)-1:0] init_cnt_reg;
  logic                          init_done_reg;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      init_cnt_reg  <= '0;
      init_done_reg <= 1'b0;
    end
    else if (!init_done_reg)
    begin
      init_cnt_reg <= init_cnt_reg + 1'b1;
      if (init_cnt_reg == ($bits(init_cnt_reg))'(INIT_CYC - 1))
        init_done_reg <= 1'b1;
    end
  end

  // Power modes
  wire touched = |button_state;
  logic [$clog2(UNIT_CYC+1)-1:0] unit_cnt_reg;
  logic [7:0]                    save_cnt_reg;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode         <= tbspi_pkg::TBSPI_NORMAL;
      unit_cnt_reg <= '0;
      save_cnt_reg <= '0;
    end
    else
    begin
      if (mode != tbspi_pkg::TBSPI_NORMAL || touched || power_save_time == 8'h00)
      begin
        unit_cnt_reg <= '0;
        save_cnt_reg <= '0;
      end
      else if (unit_cnt_reg == ($bits(unit_cnt_reg))'(UNIT_CYC - 1))
      begin
        unit_cnt_reg <= '0;
        save_cnt_reg <= save_cnt_reg + 1'b1;
      end
      else
        unit_cnt_reg <= unit_cnt_reg + 1'b1;
      unique case (mode)
        tbspi_pkg::TBSPI_NORMAL:
          if (!ps_high)
            mode <= tbspi_pkg::TBSPI_SLEEP;
          else if (power_save_time != 8'h00 && save_cnt_reg >= power_save_time)
            mode <= tbspi_pkg::TBSPI_IDLE;
        tbspi_pkg::TBSPI_IDLE:
          if (!ps_high)
            mode <= tbspi_pkg::TBSPI_SLEEP;
          else if (touched)
            mode <= tbspi_pkg::TBSPI_NORMAL;
        tbspi_pkg::TBSPI_SLEEP:
          if (ps_high)
            mode <= tbspi_pkg::TBSPI_NORMAL;
        default:
          mode <= tbspi_pkg::TBSPI_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scan_en   <= 1'b1;
      scan_fast <= 1'b1;
    end
    else
    begin
      scan_en   <= (mode != tbspi_pkg::TBSPI_SLEEP);
      scan_fast <= (mode == tbspi_pkg::TBSPI_NORMAL);
    end
  end

  // Button change reports, queued behind a slow link
  logic [BTN_W-1:0]      btn_last_reg;
  logic                  rpt_valid;
  logic                  rpt_ready;
  tbspi_pkg::tbspi_pkt_t rpt_pkt;
  tbspi_pkg::tbspi_pkt_t q_pkt;
  logic                  q_valid;
  logic                  q_ready;

  assign rpt_valid = init_done_reg && (button_state != btn_last_reg);
  assign rpt_pkt   = '{op: tbspi_pkg::OP_BTN_REPORT, arg: 24'(button_state)};

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      btn_last_reg <= '0;
    else if (rpt_valid && rpt_ready)
      btn_last_reg <= button_state;
  end

  tbspi_fifo #(
    .W (32),
    .D (tbspi_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .arst_n    (arst_n),
    .in_data   (rpt_pkt),
    .in_valid  (rpt_valid),
    .in_ready  (rpt_ready),
    .out_data  (q_pkt),
    .out_valid (q_valid),
    .out_ready (q_ready)
  );

  // Receive side: packet framing
  logic [1:0]  rx_idx_reg;
  logic [23:0] rx_acc_reg;
  logic        cmd_start;
  logic        cmd_done;

  assign cmd_start = byte_evt && rx_idx_reg == 2'd0 && rx_hold_reg != 8'h00;
  assign cmd_done  = byte_evt && rx_idx_reg == 2'd3;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_idx_reg <= '0;
      rx_acc_reg <= '0;
    end
    else if (link_clr_reg)
      rx_idx_reg <= '0;
    else if (byte_evt && (rx_idx_reg != 2'd0 || cmd_start))
    begin
      // Zero lead byte is a read filler, not a command
      rx_idx_reg <= rx_idx_reg + 1'b1;
      rx_acc_reg <= {rx_acc_reg[15:0], rx_hold_reg};
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd_valid   <= 1'b0;
      cmd_pkt     <= '0;
      sensitivity <= tbspi_pkg::SENS_RESET;
    end
    else
    begin
      cmd_valid <= cmd_done;
      if (cmd_done)
      begin
        cmd_pkt <= {rx_acc_reg, rx_hold_reg};
        if (rx_acc_reg[23:16] == tbspi_pkg::OP_SET_SENS)
          sensitivity <= rx_acc_reg[11:8];
      end
    end
  end

  // Transmit side
  logic       reply_pend_reg;
  logic [31:0] reply_reg;
  logic       hello_pend_reg;
  logic       tx_busy_reg;
  logic [1:0] tx_idx_reg;
  logic [31:0] tx_pkt_reg;
  logic       tx_load;
  logic       tx_free;

  assign tx_free = !tx_busy_reg && rx_idx_reg == 2'd0 && !byte_evt && !link_clr_reg;
  assign tx_load = tx_free && (reply_pend_reg || hello_pend_reg || q_valid);
  assign q_ready = tx_free && !reply_pend_reg && !hello_pend_reg;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reply_pend_reg <= 1'b0;
      reply_reg      <= '0;
      hello_pend_reg <= 1'b0;
    end
    else
    begin
      if (!init_done_reg && init_cnt_reg == ($bits(init_cnt_reg))'(INIT_CYC - 1))
        hello_pend_reg <= 1'b1;
      else if (tx_load && !reply_pend_reg)
        hello_pend_reg <= 1'b0;
      if (cmd_done && rx_acc_reg[23:16] == tbspi_pkg::OP_GET_SENS)
      begin
        reply_pend_reg <= 1'b1;
        reply_reg      <= {tbspi_pkg::OP_SENS_ANSWER, 12'h000, sensitivity, 8'h00};
      end
      else if (reply_valid)
      begin
        reply_pend_reg <= 1'b1;
        reply_reg      <= reply_pkt;
      end
      else if (tx_load)
        reply_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_busy_reg    <= 1'b0;
      tx_idx_reg     <= '0;
      tx_pkt_reg     <= '0;
      tx_word_reg    <= '0;
      data_request_n <= 1'b1;
    end
    else if (cmd_start || (link_clr_reg && tx_idx_reg != 2'd0))
    begin
      // Host command wins; a cut packet is dropped, an unread one keeps waiting
      tx_busy_reg    <= 1'b0;
      tx_idx_reg     <= '0;
      tx_word_reg    <= '0;
      data_request_n <= 1'b1;
    end
    else if (tx_busy_reg && byte_evt)
    begin
      tx_idx_reg  <= tx_idx_reg + 1'b1;
      tx_word_reg <= tx_pkt_reg[23:16];
      tx_pkt_reg  <= {tx_pkt_reg[23:0], 8'h00};
      if (tx_idx_reg == 2'd3)
      begin
        tx_busy_reg    <= 1'b0;
        tx_word_reg    <= '0;
        data_request_n <= 1'b1;
      end
    end
    else if (tx_load)
    begin
      tx_busy_reg    <= 1'b1;
      tx_idx_reg     <= '0;
      tx_pkt_reg     <= reply_pend_reg ? reply_reg :
                        hello_pend_reg ? tbspi_pkg::HELLO_PACKET : q_pkt;
      tx_word_reg    <= reply_pend_reg ? reply_reg[31:24] :
                        hello_pend_reg ? tbspi_pkg::HELLO_PACKET[31:24] : q_pkt[31:24];
      data_request_n <= 1'b0;
    end
  end
endmodule

// ---- logic/tbspi_pkg.sv ----
// Purpose: Constants and types for the touch button serial slave port
// Assumes: 100 MHz core clock, host-made serial clock idling high
// Notes: Tags below mark the logic that carries each rule
// Operation
// - Start in normal mode, fast scanning
// - Zero save time, save high: stay normal
// - Nonzero save time: normal falls to idle
// - Touch in idle returns normal until release
// - Save input low sleeps; high returns normal
// - Transfers are whole 8-bit units
// - Output on falling, sample on rising edge
// - One shift register moves both directions
// - Request low on button change, high after
// - Request low when reply is ready
// - Packets are four bytes each way
// - Host command aborts outgoing packet, then answered
// - Greeting packet after 350ms initialisation
// - Sensitivity 00H to 0FH, default 07H
package tbspi_pkg;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          BYTE_BITS      = 8;
  localparam int          PKT_BYTES      = 4;
  localparam longint      INIT_TIME_MS   = 350;
  localparam int          INIT_CYCLES    = int'((INIT_TIME_MS * 1000000) / CLK_PERIOD_NS);
  localparam longint      RESYNC_TIME_US = 2000;
  localparam int          RESYNC_CYCLES  = int'((RESYNC_TIME_US * 1000) / CLK_PERIOD_NS);
  localparam longint      SAVE_UNIT_US   = 1000;
  localparam int          SAVE_UNIT_CYC  = int'((SAVE_UNIT_US * 1000) / CLK_PERIOD_NS);
  localparam int          FIFO_DEPTH     = 32;
  localparam logic [3:0]  SENS_RESET     = 4'h7;
  localparam logic [7:0]  OP_SET_SENS    = 8'h54;
  localparam logic [7:0]  OP_GET_SENS    = 8'h53;
  localparam logic [7:0]  OP_SENS_ANSWER = 8'h52;
  localparam logic [7:0]  OP_BTN_REPORT  = 8'h5a;
  localparam logic [31:0] HELLO_PACKET   = 32'h55555555;

  typedef enum logic [1:0] {
    TBSPI_NORMAL = 2'b00,
    TBSPI_IDLE   = 2'b01,
    TBSPI_SLEEP  = 2'b10
  } tbspi_mode_t;

  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] arg;
  } tbspi_pkt_t;
endpackage

// ---- bench/tbspi_props.sv ----
// Purpose: Port checks for the touch button serial port
// Assumes: Core clock domain, async low reset
// Notes: Serial output is watched from the core side
module tbspi_props #(
  parameter int BTN_W = 18
) (
  input wire logic                   clock,
  input wire logic                   arst_n,
  input wire logic                   iface_sel0_or_serial_clock,
  input wire logic                   iface_sel1_or_serial_in,
  input wire logic                   iface_sel2_or_serial_out,
  input wire logic                   data_request_n,
  input wire logic                   power_save_n,
  input wire logic [7:0]             power_save_time,
  input wire logic [BTN_W-1:0]       button_state,
  input wire logic                   reply_valid,
  input wire tbspi_pkg::tbspi_pkt_t  reply_pkt,
  input wire logic                   cmd_valid,
  input wire tbspi_pkg::tbspi_pkt_t  cmd_pkt,
  input wire tbspi_pkg::tbspi_mode_t mode,
  input wire logic                   scan_en,
  input wire logic                   scan_fast,
  input wire logic [3:0]             sensitivity
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  a_reset_normal_mode: assert property ($rose(arst_n) |-> mode == tbspi_pkg::TBSPI_NORMAL && scan_fast)
    else $error("mode not normal after reset");
  a_reset_sens_value: assert property ($rose(arst_n) |-> sensitivity == 4'h7)
    else $error("sensitivity not 7 after reset");
  a_zero_time_stay: assert property (mode == tbspi_pkg::TBSPI_NORMAL && power_save_time == 8'h00
    && $past(power_save_time) == 8'h00 |=> mode != tbspi_pkg::TBSPI_IDLE)
    else $error("idle entered with zero save time");
  a_idle_needs_time: assert property (mode == tbspi_pkg::TBSPI_IDLE && $past(mode) == tbspi_pkg::TBSPI_NORMAL
    |-> $past(power_save_time) != 8'h00)
    else $error("idle entered with zero save time");
  a_touch_wakes_up: assert property (mode == tbspi_pkg::TBSPI_IDLE && |button_state
    |-> ##[1:6] mode != tbspi_pkg::TBSPI_IDLE)
    else $error("touch did not leave idle");
  a_pin_low_sleeps: assert property (!power_save_n [*7] |-> mode == tbspi_pkg::TBSPI_SLEEP && !scan_en)
    else $error("no sleep with save pin low");
  a_pin_high_wakes: assert property (power_save_n [*6] |-> mode != tbspi_pkg::TBSPI_SLEEP)
    else $error("sleep with save pin high");
  a_cmd_pkt_holds: assert property (!cmd_valid |-> $stable(cmd_pkt))
    else $error("command changed without strobe");
  a_reply_requests: assert property (reply_valid |-> ##[1:2] !data_request_n)
    else $error("reply not announced");
  a_out_low_stable: assert property (!iface_sel0_or_serial_clock && $past(!iface_sel0_or_serial_clock)
    |-> $stable(iface_sel2_or_serial_out))
    else $error("serial output moved while clock low");

  c_idle: cover property (mode == tbspi_pkg::TBSPI_IDLE);
  c_sleep: cover property (mode == tbspi_pkg::TBSPI_SLEEP);
  c_cmd: cover property (cmd_valid);
  c_req: cover property ($fell(data_request_n));
endmodule

bind tbspi_top tbspi_props #(.BTN_W(BTN_W)) u_props (.clock, .arst_n, .iface_sel0_or_serial_clock,
  .iface_sel1_or_serial_in, .iface_sel2_or_serial_out, .data_request_n, .power_save_n, .power_save_time,
  .button_state, .reply_valid, .reply_pkt, .cmd_valid, .cmd_pkt, .mode, .scan_en, .scan_fast, .sensitivity);

// ---- bench/tbspi_host.sv ----
// Purpose: Host master model for the serial port
// Assumes: Clock idles high and runs only within bytes
// Notes: Released data line reads high, as its pull-up makes it
module tbspi_host #(
  parameter int GAP_NS  = 51000,
  parameter int HALF_NS = 31250
) (
  output logic        sck,
  output logic        sdi,
  input  wire logic   sdo,
  output logic        rx_stb,
  output logic [31:0] rx_word
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sck = 1'b1;
    sdi = 1'b1;
    rx_stb = 1'b0;
    rx_word = 32'h0;
  end

  // Odd start offset keeps link edges off the core edges
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    #3;
    for (int i = 7; i >= 0; i--)
    begin
      sck = 1'b0;
      sdi = tx[i];
      #(HALF_NS);
      sck = 1'b1;
      rx[i] = sdo;
      #(HALF_NS);
    end
    sdi = 1'b1;
    #(GAP_NS);
  endtask

  task automatic xpkt(input logic [31:0] tx, input logic rd);
    logic [7:0] b;
    for (int k = 3; k >= 0; k--)
    begin
      xbyte(tx[k*8 +: 8], b);
      rx_word[k*8 +: 8] = b;
    end
    rx_stb = rd;
    #20;
    rx_stb = 1'b0;
  endtask
endmodule

// ---- bench/tbspi_top_bench.sv ----
// Purpose: Self-checking bench of the touch button serial port
// Assumes: Host model as link master, shortened counts
// Notes: Link rate raised and byte gap cut to keep the run short
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end
module tbspi_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INIT_CYC = 2000;
  localparam int UNIT_CYC = 100;
  localparam int RESYNC_CYC = 3000;
  logic                   clock, arst_n, sck, sdi, sdo, req_n, ps_n, rep_v, cmd_v, rx_stb, scan_en, scan_fast;
  logic [7:0]             ps_time, b;
  logic [17:0]            btn;
  logic [31:0]            rx_word, lfsr, exp_w, exp_c, exp_q[$], cmd_q[$];
  logic [3:0]             sens;
  tbspi_pkg::tbspi_pkt_t  rep_pkt, cmd_pkt;
  tbspi_pkg::tbspi_mode_t mode;
  int                     error_cnt, n_checks;

  tbspi_top #(.BTN_W(18), .INIT_CYC(INIT_CYC), .RESYNC_CYC(RESYNC_CYC), .UNIT_CYC(UNIT_CYC)) uut (
    .clock(clock), .arst_n(arst_n), .iface_sel0_or_serial_clock(sck), .iface_sel1_or_serial_in(sdi),
    .iface_sel2_or_serial_out(sdo), .data_request_n(req_n), .power_save_n(ps_n), .power_save_time(ps_time),
    .button_state(btn), .reply_valid(rep_v), .reply_pkt(rep_pkt), .cmd_valid(cmd_v), .cmd_pkt(cmd_pkt),
    .mode(mode), .scan_en(scan_en), .scan_fast(scan_fast), .sensitivity(sens));
  tbspi_host #(.GAP_NS(5000), .HALF_NS(80)) host (.sck(sck), .sdi(sdi), .sdo(sdo), .rx_stb(rx_stb),
    .rx_word(rx_word));

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wait_low(int lim);
    for (int i = 0; i < lim && req_n !== 1'b0; i++) @(posedge clock);
    `CHK("request", 1'b0, req_n)
  endtask

  task automatic wait_mode(tbspi_pkg::tbspi_mode_t m, int lim);
    for (int i = 0; i < lim && mode !== m; i++) @(posedge clock);
    `CHK("mode", m, mode)
  endtask

  task automatic rd(input logic [31:0] e);
    exp_q.push_back(e);
    host.xpkt(32'h0, 1'b1);
  endtask

  task automatic cmd(input logic [31:0] c);
    cmd_q.push_back(c);
    host.xpkt(c, 1'b0);
  endtask

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial
  begin
    #600000;
    error_cnt++;
    final_report();
  end

  // Oldest note popped once, so a mismatch cannot eat a second note
  initial
    forever
    begin
      @(posedge rx_stb);
      exp_w = exp_q.pop_front();
      `CHK("packet", exp_w, rx_word)
    end

  // Falling edge: strobe and packet are settled
  always @(negedge clock)
    if (cmd_v === 1'b1)
    begin
      exp_c = cmd_q.pop_front();
      `CHK("command", exp_c, cmd_pkt)
    end

  initial
  begin
    arst_n = 1'b0;
    ps_n = 1'b1;
    ps_time = 8'h00;
    btn = 18'h0;
    rep_v = 1'b0;
    rep_pkt = 32'h0;
    lfsr = 32'hba06;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    #1;
    `CHK("mode", tbspi_pkg::TBSPI_NORMAL, mode)
    `CHK("fast scan", 1'b1, scan_fast)
    `CHK("sensitivity", 4'h7, sens)
    `CHK("request", 1'b1, req_n)
    wait_low(INIT_CYC + 100);
    rd(tbspi_pkg::HELLO_PACKET);
    `CHK("request", 1'b1, req_n)
    // Two changes back to back, both reports queued
    lfsr = nxt(lfsr);
    @(posedge clock);
    btn <= lfsr[17:0] | 18'h1;
    repeat (5) @(posedge clock);
    btn <= 18'h0;
    wait_low(20);
    rd({tbspi_pkg::OP_BTN_REPORT, 6'h0, lfsr[17:0] | 18'h1});
    rd({tbspi_pkg::OP_BTN_REPORT, 24'h0});
    `CHK("request", 1'b1, req_n)
    for (int i = 0; i < 3; i++)
    begin
      b = (i == 0) ? 8'h0f : (i == 1) ? 8'h00 : 8'h0c;
      cmd({tbspi_pkg::OP_SET_SENS, b, b, 8'h00});
      `CHK("sensitivity", b[3:0], sens)
    end
    // Stray half packet must be dropped after the idle gap
    host.xbyte(tbspi_pkg::OP_SET_SENS, b);
    host.xbyte(8'h00, b);
    repeat (RESYNC_CYC + 200) @(posedge clock);
    cmd({tbspi_pkg::OP_SET_SENS, 8'h03, 8'h03, 8'h00});
    `CHK("sensitivity", 4'h3, sens)
    lfsr = nxt(lfsr);
    @(posedge clock);
    rep_v <= 1'b1;
    rep_pkt <= lfsr;
    @(posedge clock);
    rep_v <= 1'b0;
    wait_low(10);
    host.xbyte(8'h00, b);
    `CHK("reply head", lfsr[31:24], b)
    cmd({tbspi_pkg::OP_GET_SENS, 24'h0});
    wait_low(20);
    rd({tbspi_pkg::OP_SENS_ANSWER, 12'h000, 4'h3, 8'h00});
    @(posedge clock);
    ps_time <= 8'h02;
    wait_mode(tbspi_pkg::TBSPI_IDLE, 2 * UNIT_CYC + 20);
    // Scan flags trail the mode by one cycle
    @(posedge clock);
    `CHK("fast scan", 1'b0, scan_fast)
    btn <= 18'h2;
    wait_mode(tbspi_pkg::TBSPI_NORMAL, 6);
    btn <= 18'h0;
    wait_mode(tbspi_pkg::TBSPI_IDLE, 2 * UNIT_CYC + 20);
    ps_n <= 1'b0;
    wait_mode(tbspi_pkg::TBSPI_SLEEP, 6);
    @(posedge clock);
    `CHK("scan enable", 1'b0, scan_en)
    ps_time <= 8'h00;
    ps_n <= 1'b1;
    wait_mode(tbspi_pkg::TBSPI_NORMAL, 6);
    repeat (5 * UNIT_CYC) @(posedge clock);
    `CHK("mode", tbspi_pkg::TBSPI_NORMAL, mode)
    final_report();
  end
endmodule
